// ---- bvs_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module bvs_mem_model (
  input  wire logic        mclk_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  output logic      [15:0] data_out
);
  logic [7:0]  row;
  logic        ras_d;
  logic [15:0] last;
  always_ff @(posedge mclk_in)
  begin
    ras_d <= ras_n_in;
    if (ras_d && !ras_n_in) row <= addr_in;
    if (!cas_n_in) last <= data_out;
  end
  // Outside CAS the bus shows inverted stale data, so a mistimed sample shows up
  assign data_out = !cas_n_in ? {row ^ 8'h3C, row ^ addr_in ^ 8'hA5} : ~last;
endmodule
`default_nettype wire

// ---- bvs_pkg.sv ----
package bvs_pkg;
  // Phase counter: one character period is sixteen system clocks
  localparam int unsigned PHASE_W      = 4;
  localparam int unsigned PIXEL_DIV    = 2;
  localparam int unsigned CHAR_DIV     = 16;
  localparam int unsigned PIX_PER_CHAR = CHAR_DIV / PIXEL_DIV;

  // Memory word and address layout
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned PLANE_W    = 8;
  localparam int unsigned CMA_W      = 12;
  localparam int unsigned RSCAN_W    = 2;
  localparam int unsigned WADDR_W    = RSCAN_W + CMA_W;
  localparam int unsigned HALF_W     = 7;
  localparam int unsigned MADDR_W    = 8;
  localparam int unsigned LOW_LSB    = 0;
  localparam int unsigned HIGH_LSB   = 8;

  // Slot phases inside one character period
  localparam logic [3:0] PH_CPU_BASE = 4'h0;
  localparam logic [3:0] PH_CRT_BASE = 4'h8;
  localparam logic [2:0] SUB_COL     = 3'h4;
  localparam logic [2:0] SUB_RAS     = 3'h1;
  localparam logic [3:0] PH_FETCH    = 4'hE;
  localparam logic [3:0] PH_LOAD     = 4'hF;

  // Raster geometry in characters and scan lines
  localparam logic [5:0] H_DISP  = 6'h33;
  localparam logic [5:0] H_LAST  = 6'h3F;
  localparam logic [8:0] V_DISP  = 9'h130;
  localparam logic [8:0] V_LAST  = 9'h13F;
  localparam logic [1:0] RS_LAST = 2'h3;
endpackage

// ---- bvs_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module bvs_props (
  input wire logic                        mclk_in,
  input wire logic                        rst_n_in,
  input wire logic                        cpu_mem_wait_n_in,
  input wire logic [bvs_pkg::MADDR_W-1:0] mem_addr_out,
  input wire logic                        mem_ras_n_out,
  input wire logic                        mem_cas_n_out,
  input wire logic                        mem_crt_slot_out,
  input wire logic                        pixel_on_out,
  input wire logic                        half_bright_n_out,
  input wire logic                        video_display_enable_out,
  input wire logic                        cpu_mem_wait_n_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic [2:0] vid;
  assign vid = {pixel_on_out, half_bright_n_out, video_display_enable_out};
  AST_ROW_FIRST:
    assert property ($fell(mem_ras_n_out) |-> mem_cas_n_out ##0 $stable(mem_addr_out)[*3])
    else $error("row address not held around row strobe");
  AST_COL_AFTER_ROW:
    assert property ($fell(mem_cas_n_out) |-> $past(mem_ras_n_out, 5) && !$past(mem_ras_n_out, 4))
    else $error("column strobe not four cycles after row strobe");
  AST_REFRESH_SCAN:
    assert property ($fell(mem_ras_n_out) |-> ##8 $fell(mem_ras_n_out))
    else $error("row strobe cadence broken");
  AST_ADDR_TOP_ZERO:
    assert property (!mem_addr_out[bvs_pkg::MADDR_W-1])
    else $error("address top bit set");
  AST_BLANK:
    assert property (!video_display_enable_out |-> !pixel_on_out && half_bright_n_out)
    else $error("video lit while display disabled");
  AST_HALF_LIT:
    assert property (!half_bright_n_out |-> pixel_on_out)
    else $error("half level selected on dark pixel");
  AST_PIXEL_PAIR:
    assert property ($changed(vid) |=> $stable(vid))
    else $error("video changed off the pixel rate");
  AST_SLOT_HALF:
    assert property ($rose(mem_crt_slot_out) |-> mem_crt_slot_out[*8] ##1 !mem_crt_slot_out)
    else $error("display slot not half a character period");
  AST_WAIT_LATCH:
    assert property ($stable(cpu_mem_wait_n_in)[*3] |-> cpu_mem_wait_n_out == cpu_mem_wait_n_in)
    else $error("wait indication not relatched");
  cover property ($fell(mem_cas_n_out) && !mem_crt_slot_out);
  cover property (!half_bright_n_out);
  cover property ($rose(video_display_enable_out));
endmodule
bind bvs_serializer bvs_props u_props (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cpu_mem_wait_n_in(cpu_mem_wait_n_in),
  .mem_addr_out(mem_addr_out), .mem_ras_n_out(mem_ras_n_out), .mem_cas_n_out(mem_cas_n_out),
  .mem_crt_slot_out(mem_crt_slot_out), .pixel_on_out(pixel_on_out),
  .half_bright_n_out(half_bright_n_out), .video_display_enable_out(video_display_enable_out),
  .cpu_mem_wait_n_out(cpu_mem_wait_n_out));
`default_nettype wire

// ---- bvs_serializer.sv ----
`timescale 1ns/1ns
`default_nettype none
module bvs_serializer (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          cpu_req_in,
  input  wire logic [bvs_pkg::WADDR_W-1:0]   cpu_addr_in,
  input  wire logic                          cpu_mem_wait_n_in,
  input  wire logic [bvs_pkg::WORD_W-1:0]    mem_data_in,
  output logic [bvs_pkg::MADDR_W-1:0]        mem_addr_out,
  output logic                               mem_ras_n_out,
  output logic                               mem_cas_n_out,
  output logic                               mem_crt_slot_out,
  output logic                               pixel_on_out,
  output logic                               half_bright_n_out,
  output logic                               video_display_enable_out,
  output logic                               cpu_mem_wait_n_out
);
  logic [bvs_pkg::PHASE_W-1:0] phase;
  logic                        pixel_en;
  logic                        char_en;

  bvs_timing u_timing (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .phase_out    (phase),
    .pixel_en_out (pixel_en),
    .char_en_out  (char_en)
  );

  // Raster scan state
  logic [5:0]                    h_cnt;
  logic [8:0]                    v_cnt;
  logic [bvs_pkg::CMA_W-1:0]     row_base;
  logic [bvs_pkg::CMA_W-1:0]     char_mem_addr;
  logic [bvs_pkg::HALF_W-1:0]    refresh_row;
  logic                          cpu_go;
  logic [5:0]                    next_h_cnt;
  logic [8:0]                    next_v_cnt;
  logic [bvs_pkg::CMA_W-1:0]     next_row_base;
  logic [bvs_pkg::CMA_W-1:0]     next_char_mem_addr;
  logic [bvs_pkg::HALF_W-1:0]    next_refresh_row;
  logic                          next_cpu_go;
  logic [bvs_pkg::RSCAN_W-1:0]   row_scan;
  logic                          raw_display_enable;

  assign row_scan = v_cnt[1:0];
  assign raw_display_enable = (h_cnt < bvs_pkg::H_DISP) && (v_cnt < bvs_pkg::V_DISP);

  always_comb
  begin
    next_h_cnt         = h_cnt;
    next_v_cnt         = v_cnt;
    next_row_base      = row_base;
    next_char_mem_addr = char_mem_addr;
    next_refresh_row   = refresh_row;
    next_cpu_go        = cpu_go;
    if (char_en)
    begin
      // Request must stand before the period starts to win the processor slot
      next_cpu_go = cpu_req_in;
      if (!cpu_go)
        next_refresh_row = refresh_row + 7'h01;
      if (h_cnt == bvs_pkg::H_LAST)
      begin
        next_h_cnt = 6'h00;
        if (v_cnt == bvs_pkg::V_LAST)
        begin
          next_v_cnt         = 9'h000;
          next_row_base      = 12'h000;
          next_char_mem_addr = 12'h000;
        end
        else if (row_scan == bvs_pkg::RS_LAST)
        begin
          next_v_cnt         = v_cnt + 9'h001;
          next_row_base      = row_base + {6'h00, bvs_pkg::H_DISP};
          next_char_mem_addr = row_base + {6'h00, bvs_pkg::H_DISP};
        end
        else
        begin
          next_v_cnt         = v_cnt + 9'h001;
          next_char_mem_addr = row_base;
        end
      end
      else
      begin
        next_h_cnt = h_cnt + 6'h01;
        // Keeps counting through retrace; the moving address doubles as refresh
        next_char_mem_addr = char_mem_addr + 12'h001;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      h_cnt         <= 6'h00;
      v_cnt         <= 9'h000;
      row_base      <= 12'h000;
      char_mem_addr <= 12'h000;
      refresh_row   <= 7'h00;
      cpu_go        <= 1'b0;
    end
    else
    begin
      h_cnt         <= next_h_cnt;
      v_cnt         <= next_v_cnt;
      row_base      <= next_row_base;
      char_mem_addr <= next_char_mem_addr;
      refresh_row   <= next_refresh_row;
      cpu_go        <= next_cpu_go;
    end
  end

  // Memory strobes and multiplexed address
  logic [bvs_pkg::WADDR_W-1:0]   crt_word_addr;
  logic [bvs_pkg::WADDR_W-1:0]   slot_addr;
  logic [2:0]                    sub;
  logic                          crt_slot;
  logic                          slot_cas_ok;
  logic [bvs_pkg::MADDR_W-1:0]   next_mem_addr;
  logic                          next_mem_ras_n;
  logic                          next_mem_cas_n;

  assign crt_word_addr = {row_scan, char_mem_addr};
  assign crt_slot      = phase[3];
  assign sub           = phase[2:0];
  assign slot_cas_ok   = crt_slot || cpu_go;

  always_comb
  begin
    if (crt_slot)
      slot_addr = crt_word_addr;
    else if (cpu_go)
      slot_addr = cpu_addr_in;
    else
      slot_addr = {7'h00, refresh_row};
    if (sub < bvs_pkg::SUB_COL)
      next_mem_addr = {1'b0, slot_addr[bvs_pkg::HALF_W-1:0]};
    else
      next_mem_addr = {1'b0, slot_addr[bvs_pkg::WADDR_W-1:bvs_pkg::HALF_W]};
    next_mem_ras_n = !(sub >= bvs_pkg::SUB_RAS);
    // Idle processor slots run RAS-only refresh cycles
    next_mem_cas_n = !((sub > bvs_pkg::SUB_COL) && slot_cas_ok);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mem_addr_out     <= 8'h00;
      mem_ras_n_out    <= 1'b1;
      mem_cas_n_out    <= 1'b1;
      mem_crt_slot_out <= 1'b0;
    end
    else
    begin
      mem_addr_out     <= next_mem_addr;
      mem_ras_n_out    <= next_mem_ras_n;
      mem_cas_n_out    <= next_mem_cas_n;
      mem_crt_slot_out <= crt_slot;
    end
  end

  // Fetch, plane shift registers and output latch
  logic [bvs_pkg::WORD_W-1:0]    fetch_word;
  logic                          fetch_de;
  logic [bvs_pkg::PLANE_W-1:0]   full_plane;
  logic [bvs_pkg::PLANE_W-1:0]   half_plane;
  logic                          load_de;
  logic                          load_n;
  logic [bvs_pkg::WORD_W-1:0]    next_fetch_word;
  logic                          next_fetch_de;
  logic [bvs_pkg::PLANE_W-1:0]   next_full_plane;
  logic [bvs_pkg::PLANE_W-1:0]   next_half_plane;
  logic                          next_load_de;
  logic                          next_pixel_on;
  logic                          next_half_bright_n;
  logic                          next_vde;
  logic                          next_wait_n;
  logic                          full_bit;
  logic                          half_bit;

  assign load_n   = !(phase == bvs_pkg::PH_LOAD);
  assign full_bit = full_plane[bvs_pkg::PLANE_W-1];
  assign half_bit = half_plane[bvs_pkg::PLANE_W-1];

  always_comb
  begin
    next_fetch_word    = fetch_word;
    next_fetch_de      = fetch_de;
    next_full_plane    = full_plane;
    next_half_plane    = half_plane;
    next_load_de       = load_de;
    next_pixel_on      = pixel_on_out;
    next_half_bright_n = half_bright_n_out;
    next_vde           = video_display_enable_out;
    next_wait_n        = cpu_mem_wait_n_out;
    if (phase == bvs_pkg::PH_FETCH)
    begin
      next_fetch_word = mem_data_in;
      next_fetch_de   = raw_display_enable;
    end
    if (pixel_en)
    begin
      if (!load_n)
      begin
        next_full_plane = fetch_word[bvs_pkg::LOW_LSB +: bvs_pkg::PLANE_W];
        next_half_plane = fetch_word[bvs_pkg::HIGH_LSB +: bvs_pkg::PLANE_W];
        next_load_de    = fetch_de;
      end
      else
      begin
        next_full_plane = {full_plane[bvs_pkg::PLANE_W-2:0], 1'b0};
        next_half_plane = {half_plane[bvs_pkg::PLANE_W-2:0], 1'b0};
      end
      // Full plane wins when both bits are set
      next_pixel_on      = load_de && (full_bit || half_bit);
      next_half_bright_n = !(load_de && half_bit && !full_bit);
      next_vde           = load_de;
      next_wait_n        = cpu_mem_wait_n_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fetch_word               <= 16'h0000;
      fetch_de                 <= 1'b0;
      full_plane               <= 8'h00;
      half_plane               <= 8'h00;
      load_de                  <= 1'b0;
      pixel_on_out             <= 1'b0;
      half_bright_n_out        <= 1'b1;
      video_display_enable_out <= 1'b0;
      cpu_mem_wait_n_out       <= 1'b1;
    end
    else
    begin
      fetch_word               <= next_fetch_word;
      fetch_de                 <= next_fetch_de;
      full_plane               <= next_full_plane;
      half_plane               <= next_half_plane;
      load_de                  <= next_load_de;
      pixel_on_out             <= next_pixel_on;
      half_bright_n_out        <= next_half_bright_n;
      video_display_enable_out <= next_vde;
      cpu_mem_wait_n_out       <= next_wait_n;
    end
  end
endmodule
`default_nettype wire

// ---- bvs_timing.sv ----
`timescale 1ns/1ns
`default_nettype none
module bvs_timing (
  input  wire logic                        mclk_in,
  input  wire logic                        rst_n_in,
  output logic [bvs_pkg::PHASE_W-1:0]      phase_out,
  output logic                             pixel_en_out,
  output logic                             char_en_out
);
  logic [bvs_pkg::PHASE_W-1:0] phase;
  logic [bvs_pkg::PHASE_W-1:0] next_phase;

  always_comb
  begin
    next_phase = phase + 4'h1;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      phase <= 4'h0;
    else
      phase <= next_phase;
  end

  assign phase_out    = phase;
  assign pixel_en_out = phase[0];
  assign char_en_out  = (phase == bvs_pkg::PH_LOAD);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        cpu_req_in = 1'b0;
  logic [13:0] cpu_addr_in = 14'h2A5B;
  logic        wait_n = 1'b1;
  wire logic [15:0] mem_data;
  wire logic [7:0]  maddr;
  wire logic   ras_n, cas_n, slot, pon, hbn, video_display_enable, wout;
  int          n_mismatch = 0;
  int          num_checks = 0;
  logic [3:0]  ph;
  logic [15:0] p, cur_ch, cap, nxt, cur;
  logic        cv;
  always #20 mclk_in = ~mclk_in;
  bvs_serializer uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cpu_req_in(cpu_req_in),
    .cpu_addr_in(cpu_addr_in), .cpu_mem_wait_n_in(wait_n), .mem_data_in(mem_data),
    .mem_addr_out(maddr), .mem_ras_n_out(ras_n), .mem_cas_n_out(cas_n),
    .mem_crt_slot_out(slot), .pixel_on_out(pon), .half_bright_n_out(hbn),
    .video_display_enable_out(video_display_enable), .cpu_mem_wait_n_out(wout));
  bvs_mem_model u_mem (.mclk_in(mclk_in), .addr_in(maddr), .ras_n_in(ras_n),
    .cas_n_in(cas_n), .data_out(mem_data));
  // Reference pipeline: fetch at phase 14, load at 15, first pixel after phase 1
  always @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      ph <= 4'h0;
      p <= 16'h0000;
      cv <= 1'b0;
    end
    else
    begin
      ph <= ph + 4'h1;
      if (ph == 4'hE) cap <= mem_data;
      if (ph == 4'hF) nxt <= cap;
      if (ph == 4'hF) p <= p + 16'h0001;
      if (ph == 4'h1) cur <= nxt;
      if (ph == 4'h1) cur_ch <= p - 16'h0001;
      if (ph == 4'h1) cv <= (p != 16'h0000);
    end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_reset(input int n);
    rst_n_in = 1'b0;
    repeat (n) @(negedge mclk_in);
    chk("reset outputs", 16'h0065, {9'h000, ras_n, cas_n, slot, pon, hbn, video_display_enable, wout});
    rst_n_in = 1'b1;
  endtask
  // Only even phases are judged: each pixel stands two clocks
  task automatic t_video(input int n);
    logic [2:0]  b;
    logic        vd;
    logic [15:0] e;
    logic [15:0] a;
    logic [11:0] ca;
    for (int c = 0; c < n; c++)
    begin
      @(negedge mclk_in);
      if (!ph[0])
      begin
        b = 3'h7 - 3'((ph - 4'h2) >> 1);
        vd = cv && (cur_ch[5:0] < bvs_pkg::H_DISP);
        e = {13'h0000, vd, vd & (cur[b] | cur[b + 8]), !(vd & cur[b + 8] & !cur[b])};
        chk("video", e, {13'h0000, video_display_enable, pon, hbn});
        // Memory data encode latched row and column, so the fetch address can be recovered
        if (ph == 4'h2 && cv && cur_ch[15:9] == 7'h00)
        begin
          a  = {cur[7:0] ^ cur[15:8] ^ 8'h99, cur[15:8] ^ 8'h3C};
          ca = {6'h00, cur_ch[5:0]} + (cur_ch[8] ? {6'h00, bvs_pkg::H_DISP} : 12'h000);
          chk("display address", {2'h0, cur_ch[7:6], ca}, {2'h0, a[14:8], a[6:0]});
        end
      end
    end
  endtask
  task automatic mem_slots(input logic req);
    logic       rp;
    logic       cp;
    logic       seen;
    logic       done;
    logic [7:0] row;
    rp = 1'b1;
    cp = 1'b1;
    seen = 1'b0;
    done = 1'b0;
    row = 8'h00;
    cpu_req_in = req;
    for (int k = 0; k < 48 && !done; k++)
    begin
      @(negedge mclk_in);
      if (rp && !ras_n && !slot)
      begin
        if (seen && !req) chk("refresh row", {8'h00, (row + 8'h01) & 8'h7F}, {8'h00, maddr});
        row = maddr;
        seen = 1'b1;
      end
      if (cp && !cas_n && !slot)
      begin
        chk("cpu access", 16'h0001, {15'h0000, req});
        chk("cpu address", {2'h0, cpu_addr_in}, {2'h0, maddr[6:0], row[6:0]});
        done = 1'b1;
      end
      rp = ras_n;
      cp = cas_n;
    end
    if (req)
      cpu_req_in = 1'b0;
    // A missing grant counts as a mismatch; the run still closes in one place
    if (req && !done)
      chk("grant timeout", 16'h0001, 16'h0000);
  endtask
  task automatic t_wait();
    for (int i = 0; i < 3; i++)
    begin
      wait_n = i[0];
      repeat (4) @(negedge mclk_in);
      chk("wait latch", {15'h0000, wait_n}, {15'h0000, wout});
    end
    wait_n = 1'b1;
  endtask
  initial
  begin
    t_reset(4);
    t_video(4400);
    mem_slots(1'b0);
    mem_slots(1'b1);
    t_wait();
    t_video(200);
    t_reset(2);
    t_video(1100);
    complete_run();
  end
endmodule
`default_nettype wire
